//--- hdl/rx_address_filter_config.v
// Operation
// R1: Mode 00 rejects every frame.
// R2: Mode 01 normal: ID, broadcast, multicast-ID bits.
// R3: Mode 10 normal: ID, broadcast, hashed multicast.
// R4: Mode 11 normal: accept all foreign frames.
// R5: Loopback mode rejects all foreign frames.
// R6: Own frames: full set in loopback, else ID.
// R7: Own frames mode 11: reject if self-filter in normal.
// R8: ID match: bit0 zero, bits 47:1 equal.
// R9: Multicast when first transmitted bit is one.
// R10: Accept needs address pass and error pass.
// R11: Config bit 7 low enables link; resets high.
// R12: Software keeps link disabled during setup.
// R13: Software writes ID, hash only while disabled.
// R14: Config bit 6 selects SRAM cycle 100/150 ns.
// R15: Config bit 5 selects host bus width.
// R16: Config bit 4 selects buffer memory width.
// R17: Decide acceptance before committing frame to ring.
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rx_address_filter_config_defines.vh"

module rx_address_filter_config #(
  parameter CNT_W = 8 // Width of the accept and reject counters
) (
  input wire clk, // 200 MHz clock
  input wire arst_n, // Asynchronous reset, active low
  input wire [5:0] avs_address, // Avalon byte address
  input wire avs_read, // Avalon read request
  input wire avs_write, // Avalon write request
  input wire [31:0] avs_writedata, // Avalon write data
  input wire [3:0] avs_byteenable, // Avalon byte enables
  output reg [31:0] avs_readdata, // Avalon read data
  output reg avs_waitrequest, // Avalon wait request
  input wire frame_valid, // Destination address of a frame is ready
  input wire [47:0] frame_dest, // Destination address, bit 0 first
  input wire frame_own, // Frame is own transmission
  input wire [5:0] frame_hash_idx, // Hash table index of the frame
  input wire frame_err_ok, // Frame passed the error filter
  output reg frame_accept, // Commit frame to the ring buffer
  output reg frame_reject, // Drop frame
  output reg link_disable, // High holds receiver and transmitter off
  output reg sram_cycle_select, // High 100 ns, low 150 ns
  output reg host_bus_width, // High 8-bit host bus, low word
  output reg buffer_mem_width, // High 8-bit buffer, low word
  output reg [5:0] sram_cycles // Buffer SRAM cycle in clocks
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Merge write data into an old word under byte enables
  function [31:0] be_merge;
    input [31:0] old_val;
    input [31:0] wdata;
    input [3:0] be;
    integer i;
    begin
      be_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = wdata[i*8 +: 8];
        end
      end
    end
  endfunction

  // Saturating increment of a counter
  function [CNT_W-1:0] sat_inc;
    input [CNT_W-1:0] val;
    begin
      if (&val) begin
        sat_inc = val;
      end else begin
        sat_inc = val + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  // Configuration fields
  reg [3:0] cfg0_hi_r;
  reg [1:0] filter_mode_r;
  reg loopback_ctl_r;
  reg self_filter_r;

  // Filter tables
  reg [47:0] station_id_r;
  reg [63:0] hash_table_r;

  // Decision history and counters
  reg last_accept_r;
  reg [CNT_W-1:0] accept_cnt_r;
  reg [CNT_W-1:0] reject_cnt_r;

  // SRAM cycle counts; the port takes their low six bits
  localparam [31:0] FAST_CLKS = `SRAM_FAST_CLKS;
  localparam [31:0] SLOW_CLKS = `SRAM_SLOW_CLKS;

  // Handshake strobes
  wire req;
  wire wr_commit;
  wire rd_load;

  // Merged write words
  wire [31:0] wr_sid_lo;
  wire [31:0] wr_sid_hi;
  wire [31:0] wr_hash_lo;
  wire [31:0] wr_hash_hi;
  wire [31:0] wr_cfg0;
  wire [31:0] wr_rx;
  wire [31:0] wr_tx;
  wire [31:0] wr_own;

  // Read mux output
  reg [31:0] rd_word;

  // ----------------------------------------------------------------------
  // Avalon handshake
  // ----------------------------------------------------------------------

  // Read data are loaded on the first edge, write commits on the second
  assign req = avs_read | avs_write;
  assign rd_load = avs_read && avs_waitrequest;
  assign wr_commit = avs_write && !avs_waitrequest;

  // Wait request drops for one cycle per request
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  // ----------------------------------------------------------------------
  // Write merging
  // ----------------------------------------------------------------------
  // Configuration and mode words
  assign wr_cfg0 = be_merge({24'h000000, cfg0_hi_r, 4'h0}, avs_writedata, avs_byteenable);
  assign wr_rx = be_merge({30'h00000000, filter_mode_r}, avs_writedata, avs_byteenable);
  assign wr_tx = be_merge({30'h00000000, loopback_ctl_r, 1'b0}, avs_writedata, avs_byteenable);
  assign wr_own = be_merge({31'h00000000, self_filter_r}, avs_writedata, avs_byteenable);

  // Station ID and hash words
  assign wr_sid_lo = be_merge(station_id_r[31:0], avs_writedata, avs_byteenable);
  assign wr_sid_hi = be_merge({16'h0000, station_id_r[47:32]}, avs_writedata, avs_byteenable);
  assign wr_hash_lo = be_merge(hash_table_r[31:0], avs_writedata, avs_byteenable);
  assign wr_hash_hi = be_merge(hash_table_r[63:32], avs_writedata, avs_byteenable);

  // Register writes; unmapped offsets are ignored
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg0_hi_r <= `RST_CFG0_HI; // [R11] [R14] [R15] [R16]
      filter_mode_r <= `RST_RX_MODE;
      loopback_ctl_r <= `RST_LOOPBACK;
      self_filter_r <= `RST_SELF_FILTER;
      station_id_r <= 48'h000000000000;
      hash_table_r <= 64'h0000000000000000;
    end else if (wr_commit) begin
      if (avs_address[5:2] == `OFS_CONFIG0 >> 2) begin
        cfg0_hi_r <= wr_cfg0[7:4]; // [R11] [R14] [R15] [R16]
      end else if (avs_address[5:2] == `OFS_RX_MODE >> 2) begin
        filter_mode_r <= wr_rx[1:0];
      end else if (avs_address[5:2] == `OFS_TX_MODE >> 2) begin
        loopback_ctl_r <= wr_tx[`TX_MODE_LOOPBACK_BIT];
      end else if (avs_address[5:2] == `OFS_OWN_FILTER >> 2) begin
        self_filter_r <= wr_own[`OWN_FILTER_SELF_BIT];
      end else if (avs_address[5:2] == `OFS_SID_LO >> 2) begin
        station_id_r[31:0] <= wr_sid_lo; // [R13]
      end else if (avs_address[5:2] == `OFS_SID_HI >> 2) begin
        station_id_r[47:32] <= wr_sid_hi[15:0]; // [R13]
      end else if (avs_address[5:2] == `OFS_HASH_LO >> 2) begin
        hash_table_r[31:0] <= wr_hash_lo; // [R13]
      end else if (avs_address[5:2] == `OFS_HASH_HI >> 2) begin
        hash_table_r[63:32] <= wr_hash_hi; // [R13]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------

  // Unused bits and unmapped offsets read as zero
  always @* begin
    rd_word = 32'h00000000;
    if (avs_address[5:2] == `OFS_CONFIG0 >> 2) begin
      rd_word = {24'h000000, cfg0_hi_r, 4'h0};
    end else if (avs_address[5:2] == `OFS_RX_MODE >> 2) begin
      rd_word = {30'h00000000, filter_mode_r};
    end else if (avs_address[5:2] == `OFS_TX_MODE >> 2) begin
      rd_word = {30'h00000000, loopback_ctl_r, 1'b0};
    end else if (avs_address[5:2] == `OFS_OWN_FILTER >> 2) begin
      rd_word = {31'h00000000, self_filter_r};
    end else if (avs_address[5:2] == `OFS_SID_LO >> 2) begin
      rd_word = station_id_r[31:0];
    end else if (avs_address[5:2] == `OFS_SID_HI >> 2) begin
      rd_word = {16'h0000, station_id_r[47:32]};
    end else if (avs_address[5:2] == `OFS_HASH_LO >> 2) begin
      rd_word = hash_table_r[31:0];
    end else if (avs_address[5:2] == `OFS_HASH_HI >> 2) begin
      rd_word = hash_table_r[63:32];
    end else if (avs_address[5:2] == `OFS_STATUS >> 2) begin
      rd_word[0] = last_accept_r;
      rd_word[1] = link_disable;
      rd_word[8 +: CNT_W] = accept_cnt_r;
      rd_word[16 +: CNT_W] = reject_cnt_r;
    end
  end

  // Read data register, held through the answer cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_load) begin
      avs_readdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------------

  // Configuration bits drive the rest of the controller from flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_disable <= 1'b1; // [R11]
      sram_cycle_select <= 1'b0; // [R14]
      host_bus_width <= 1'b1; // [R15]
      buffer_mem_width <= 1'b1; // [R16]
      sram_cycles <= 6'h00;
    end else begin
      link_disable <= cfg0_hi_r[`CFG0_LINK_DIS_BIT-4]; // [R11]
      sram_cycle_select <= cfg0_hi_r[`CFG0_SRAM_BIT-4]; // [R14]
      host_bus_width <= cfg0_hi_r[`CFG0_HOST_W_BIT-4]; // [R15]
      buffer_mem_width <= cfg0_hi_r[`CFG0_BUF_W_BIT-4]; // [R16]
      // Cycle count follows the same bit
      if (cfg0_hi_r[`CFG0_SRAM_BIT-4]) begin
        sram_cycles <= FAST_CLKS[5:0]; // [R14]
      end else begin
        sram_cycles <= SLOW_CLKS[5:0]; // [R14]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Acceptance decision
  // ----------------------------------------------------------------------
  // Decision path nets
  wire addr_ok;
  wire hash_hit;
  wire frame_pass;

  // Hash table bit selected by the frame's index
  assign hash_hit = hash_table_r[frame_hash_idx];

  // Mode table lookup for the destination address
  addr_accept_decide u_decide (
    .filter_mode(filter_mode_r),
    .loopback_ctl(loopback_ctl_r),
    .self_filter(self_filter_r),
    .own_frame(frame_own),
    .dest(frame_dest),
    .station_id(station_id_r),
    .hash_hit(hash_hit),
    .accept(addr_ok)
  );

  // Address and error filters both pass, link enabled
  assign frame_pass = addr_ok && frame_err_ok && !link_disable; // [R10] [R11]

  // One-cycle verdict before the frame is committed to the ring
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_accept <= 1'b0;
      frame_reject <= 1'b0;
      last_accept_r <= 1'b0;
      accept_cnt_r <= {CNT_W{1'b0}};
      reject_cnt_r <= {CNT_W{1'b0}};
    end else begin
      // Exactly one verdict pulse per offered frame
      frame_accept <= frame_valid && frame_pass; // [R17] [R10]
      frame_reject <= frame_valid && !frame_pass; // [R17]
      // Count every decision, saturating at the top
      if (frame_valid) begin
        last_accept_r <= frame_pass;
        if (frame_pass) begin
          accept_cnt_r <= sat_inc(accept_cnt_r);
        end else begin
          reject_cnt_r <= sat_inc(reject_cnt_r);
        end
      end
    end
  end

endmodule // rx_address_filter_config
`default_nettype wire

//--- hdl/rx_address_filter_config_defines.vh
`ifndef RX_ADDRESS_FILTER_CONFIG_DEFINES_VH
`define RX_ADDRESS_FILTER_CONFIG_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define OFS_CONFIG0 6'h00
`define OFS_RX_MODE 6'h04
`define OFS_TX_MODE 6'h08
`define OFS_OWN_FILTER 6'h0c
`define OFS_SID_LO 6'h10
`define OFS_SID_HI 6'h14
`define OFS_HASH_LO 6'h18
`define OFS_HASH_HI 6'h1c
`define OFS_STATUS 6'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFG0_LINK_DIS_BIT 7
`define CFG0_SRAM_BIT 6
`define CFG0_HOST_W_BIT 5
`define CFG0_BUF_W_BIT 4
`define TX_MODE_LOOPBACK_BIT 1
`define OWN_FILTER_SELF_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CFG0_HI 4'hb
`define RST_RX_MODE 2'h2
`define RST_LOOPBACK 1'b0
`define RST_SELF_FILTER 1'b0

// ----------------------------------------------------------------------
// Filter mode codes
// ----------------------------------------------------------------------
`define MODE_REJECT 2'h0
`define MODE_ID_MCAST 2'h1
`define MODE_HASH 2'h2
`define MODE_ALL 2'h3

// ----------------------------------------------------------------------
// Timing: buffer SRAM cycle times and clock period
// ----------------------------------------------------------------------
`define SRAM_FAST_NS 100
`define SRAM_SLOW_NS 150
`define CLK_PERIOD_NS 5
`define SRAM_FAST_CLKS ((`SRAM_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SRAM_SLOW_CLKS ((`SRAM_SLOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hdl/addr_accept_decide.v
`timescale 1ns/1ps
`default_nettype none
`include "rx_address_filter_config_defines.vh"

// Pure combinational destination-address acceptance decision
module addr_accept_decide (
  input wire [1:0] filter_mode, // Address-filter mode field
  input wire loopback_ctl, // Low selects loopback mode
  input wire self_filter, // Self-receive filter bit
  input wire own_frame, // Frame is the node's own transmission
  input wire [47:0] dest, // Destination address, bit 0 sent first
  input wire [47:0] station_id, // Station ID
  input wire hash_hit, // Hash table bit for this frame
  output reg accept // Address accepted
);

  // ----------------------------------------------------------------------
  // Address classes
  // ----------------------------------------------------------------------
  wire id_match;
  wire bcast;
  wire mcast;
  wire mcast_id;
  wire mcast_hash;
  wire full_set;

  // First bit zero, remaining 47 bits equal to the station ID
  assign id_match = (dest[0] == 1'b0) && (dest[47:1] == station_id[47:1]); // [R8]
  assign bcast = &dest;
  // First transmitted bit set marks a group address
  assign mcast = dest[0]; // [R9]
  assign mcast_id = mcast && (dest[23:1] == station_id[23:1]); // [R2]
  assign mcast_hash = mcast && hash_hit; // [R3]
  // Full acceptance set of the two filtering modes
  assign full_set = (filter_mode == `MODE_ID_MCAST) ? (id_match | bcast | mcast_id) :
                    (id_match | bcast | mcast_hash);

  // ----------------------------------------------------------------------
  // Decision table
  // ----------------------------------------------------------------------
  always @* begin
    accept = 1'b0;
    if (filter_mode == `MODE_REJECT) begin
      accept = 1'b0; // [R1]
    end else if (!own_frame) begin
      if (!loopback_ctl) begin
        accept = 1'b0; // [R5]
      end else if (filter_mode == `MODE_ALL) begin
        accept = 1'b1; // [R4]
      end else begin
        accept = full_set; // [R2] [R3]
      end
    end else begin
      if (filter_mode == `MODE_ALL) begin
        accept = !(loopback_ctl && self_filter); // [R7]
      end else if (loopback_ctl) begin
        accept = id_match; // [R6]
      end else begin
        accept = full_set; // [R6]
      end
    end
  end

endmodule // addr_accept_decide
`default_nettype wire

//--- verification/rx_filter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_address_filter_config_defines.vh"

// ------------------------------------------------------------
// Port checker for the address filter and configuration bits
// ------------------------------------------------------------
module rx_filter_asserts (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic [5:0] avs_address, // Bus address
  input wire logic avs_read, // Bus read
  input wire logic avs_write, // Bus write
  input wire logic [31:0] avs_writedata, // Bus write data
  input wire logic [3:0] avs_byteenable, // Bus byte enables
  input wire logic avs_waitrequest, // Bus wait
  input wire logic frame_valid, // Frame offered
  input wire logic frame_own, // Own transmission
  input wire logic frame_err_ok, // Error filter passed
  input wire logic frame_accept, // Accept pulse
  input wire logic frame_reject, // Reject pulse
  input wire logic link_disable, // Link off
  input wire logic sram_cycle_select, // Fast SRAM
  input wire logic host_bus_width, // Byte host bus
  input wire logic buffer_mem_width, // Byte buffer
  input wire logic [5:0] sram_cycles // SRAM cycle in clocks
);
  logic [1:0] mode_r;
  logic lb_r;
  logic self_r;
  logic live_r;
  logic commit;

  assign commit = avs_write && !avs_waitrequest && avs_byteenable[0];

  // Shadow of the filter settings, updated at the write commit edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= `RST_RX_MODE;
      lb_r <= `RST_LOOPBACK;
      self_r <= `RST_SELF_FILTER;
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
      if (commit && avs_address == `OFS_RX_MODE) mode_r <= avs_writedata[1:0];
      if (commit && avs_address == `OFS_TX_MODE) lb_r <= avs_writedata[1];
      if (commit && avs_address == `OFS_OWN_FILTER) self_r <= avs_writedata[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence cfg_commit;
    commit && avs_address == `OFS_CONFIG0;
  endsequence
  sequence settle_two;
    ##2 1'b1;
  endsequence

  chk_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("wait not lowered after one cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low for more than one cycle");
  chk_one_decision: assert property (frame_valid |=> frame_accept != frame_reject)
    else $error("no single decision after frame");
  chk_no_stray: assert property (!frame_valid |=> !frame_accept && !frame_reject)
    else $error("decision pulse without frame");
  chk_err_drop: assert property (frame_valid && !frame_err_ok |=> frame_reject)
    else $error("errored frame not rejected");
  chk_disabled_drop: assert property (frame_valid && link_disable |=> frame_reject)
    else $error("frame accepted while link disabled");
  chk_mode_zero: assert property (frame_valid && mode_r == `MODE_REJECT |=> frame_reject)
    else $error("mode zero accepted a frame");
  chk_loop_foreign: assert property (frame_valid && !frame_own && !lb_r |=> frame_reject)
    else $error("foreign frame accepted in loopback");
  chk_accept_all: assert property (frame_valid && !frame_own && lb_r
    && mode_r == `MODE_ALL && frame_err_ok && !link_disable |=> frame_accept)
    else $error("accept-all mode rejected a frame");
  chk_self_drop: assert property (frame_valid && frame_own && lb_r && self_r
    && mode_r == `MODE_ALL |=> frame_reject)
    else $error("own frame kept despite self filter");
  chk_cfg_follow: assert property (cfg_commit |-> settle_two
    ##0 ({link_disable, sram_cycle_select, host_bus_width, buffer_mem_width}
    == $past(avs_writedata[7:4], 2)))
    else $error("configuration outputs differ from written bits");
  chk_sram_clocks: assert property (live_r
    && sram_cycle_select == $past(sram_cycle_select)
    && sram_cycle_select == $past(sram_cycle_select, 2) |-> sram_cycles
    == (sram_cycle_select ? `SRAM_FAST_CLKS : `SRAM_SLOW_CLKS))
    else $error("SRAM cycle count wrong");
endmodule // rx_filter_asserts

bind rx_address_filter_config rx_filter_asserts u_chk (.clk, .arst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .frame_valid, .frame_own,
  .frame_err_ok, .frame_accept, .frame_reject, .link_disable, .sram_cycle_select,
  .host_bus_width, .buffer_mem_width, .sram_cycles);

`default_nettype wire

//--- verification/net_frame_source.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Network side: offers one destination address per call
// ------------------------------------------------------------
module net_frame_source (
  input wire logic clk, // Clock
  output var logic frame_valid, // Frame offered
  output var logic [47:0] frame_dest, // Destination address
  output var logic frame_own, // Own transmission
  output var logic [5:0] frame_hash_idx, // Hash index
  output var logic frame_err_ok, // Error filter passed
  input wire logic frame_accept, // Accept pulse
  input wire logic frame_reject // Reject pulse
);
  // Idle lines at time zero
  initial begin
    frame_valid = 1'b0;
    frame_dest = 48'h0;
    frame_own = 1'b0;
    frame_hash_idx = 6'h0;
    frame_err_ok = 1'b0;
  end

  // One-cycle offer; fields flip afterwards so stale values never match
  task automatic send(input logic [47:0] d, input logic own, input logic [5:0] h,
    input logic ok, output logic [1:0] ar);
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_dest <= d;
    frame_own <= own;
    frame_hash_idx <= h;
    frame_err_ok <= ok;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame_dest <= ~d;
    frame_own <= ~own;
    frame_hash_idx <= ~h;
    frame_err_ok <= ~ok;
    @(posedge clk);
    ar = {frame_accept, frame_reject};
  endtask
endmodule // net_frame_source

`default_nettype wire

//--- verification/rx_address_filter_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_address_filter_config_defines.vh"

// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module rx_address_filter_config_bench;
  localparam logic [47:0] ID = 48'h123456789abc;
  localparam logic [47:0] BC = 48'hffffffffffff;
  localparam logic [47:0] MCID = {24'h0f0f0f, ID[23:1], 1'b1};
  localparam logic [47:0] MCH = 48'h000000000003;
  localparam logic [47:0] OTH = ID ^ 48'h000000000100;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic frame_valid, frame_own, frame_err_ok, frame_accept, frame_reject;
  logic [47:0] frame_dest;
  logic [5:0] frame_hash_idx, sram_cycles;
  logic link_disable, sram_cycle_select, host_bus_width, buffer_mem_width;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  // Clock at 200 MHz and run ceiling
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  rx_address_filter_config dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_valid(frame_valid), .frame_dest(frame_dest),
    .frame_own(frame_own), .frame_hash_idx(frame_hash_idx), .frame_err_ok(frame_err_ok),
    .frame_accept(frame_accept), .frame_reject(frame_reject), .link_disable(link_disable),
    .sram_cycle_select(sram_cycle_select), .host_bus_width(host_bus_width),
    .buffer_mem_width(buffer_mem_width), .sram_cycles(sram_cycles));

  net_frame_source u_net (.clk(clk), .frame_valid(frame_valid), .frame_dest(frame_dest),
    .frame_own(frame_own), .frame_hash_idx(frame_hash_idx), .frame_err_ok(frame_err_ok),
    .frame_accept(frame_accept), .frame_reject(frame_reject));

  // Compare and count
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus transfer held until wait is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Reset values, unmapped place, frame while disabled
  task automatic t_reset();
    logic [31:0] q;
    logic [1:0] ar;
    bus(1'b0, `OFS_CONFIG0, 32'h0, q);
    check("config0", q, 48'hb0);
    check("cfg ports", {link_disable, sram_cycle_select, host_bus_width, buffer_mem_width,
      sram_cycles}, {4'hb, 6'h1e});
    bus(1'b0, `OFS_RX_MODE, 32'h0, q);
    check("filter mode", q, 48'h2);
    bus(1'b1, 6'h24, 32'hffffffff, q);
    bus(1'b0, 6'h24, 32'h0, q);
    check("unmapped", q, 48'h0);
    u_net.send(ID, 1'b0, 6'h0, 1'b1, ar);
    check("disabled frame", ar, 48'h1);
  endtask

  // Station ID and hash while disabled, then enable with word widths
  task automatic t_setup();
    logic [31:0] q;
    bus(1'b1, `OFS_SID_LO, ID[31:0], q);
    bus(1'b1, `OFS_SID_HI, {16'h0, ID[47:32]}, q);
    bus(1'b1, `OFS_HASH_LO, 32'h00000020, q);
    bus(1'b1, `OFS_HASH_HI, 32'h0, q);
    bus(1'b1, `OFS_CONFIG0, 32'h40, q);
    repeat (3) @(posedge clk);
    check("cfg ports", {link_disable, sram_cycle_select, host_bus_width, buffer_mem_width,
      sram_cycles}, {4'h4, 6'h14});
    bus(1'b0, `OFS_CONFIG0, 32'h0, q);
    check("config0", q, 48'h40);
  endtask

  // Program mode, loopback and self filter, then offer one frame
  task automatic fc(input logic [1:0] m, input logic lb, input logic sf, input logic own,
    input logic [47:0] d, input logic [5:0] h, input logic ok, input logic exp);
    logic [31:0] q;
    logic [1:0] ar;
    bus(1'b1, `OFS_RX_MODE, {30'h0, m}, q);
    bus(1'b1, `OFS_TX_MODE, {30'h0, lb, 1'b0}, q);
    bus(1'b1, `OFS_OWN_FILTER, {31'h0, sf}, q);
    u_net.send(d, own, h, ok, ar);
    check("decision", ar, exp ? 48'h2 : 48'h1);
  endtask

  // Acceptance table over every mode
  task automatic t_filter();
    fc(2'h0, 1, 0, 0, ID, 5, 1, 0);
    fc(2'h0, 0, 0, 1, ID, 5, 1, 0);
    fc(2'h1, 1, 0, 0, ID, 6, 1, 1);
    fc(2'h1, 1, 0, 0, BC, 6, 1, 1);
    fc(2'h1, 1, 0, 0, MCID, 6, 1, 1);
    fc(2'h1, 1, 0, 0, MCH, 5, 1, 0);
    fc(2'h1, 1, 0, 0, ID ^ 48'h800000000000, 6, 1, 0);
    fc(2'h1, 1, 0, 0, OTH, 6, 1, 0);
    fc(2'h2, 1, 0, 0, ID, 6, 1, 1);
    fc(2'h2, 1, 0, 0, MCH, 5, 1, 1);
    fc(2'h2, 1, 0, 0, MCH, 6, 1, 0);
    fc(2'h2, 1, 0, 0, MCID, 6, 1, 0);
    fc(2'h3, 1, 1, 0, OTH, 6, 1, 1);
    fc(2'h3, 1, 0, 0, OTH, 6, 0, 0);
    fc(2'h1, 0, 0, 0, ID, 6, 1, 0);
    fc(2'h3, 0, 0, 0, ID, 6, 1, 0);
    fc(2'h1, 0, 0, 1, BC, 6, 1, 1);
    fc(2'h1, 1, 0, 1, BC, 6, 1, 0);
    fc(2'h2, 1, 0, 1, ID, 6, 1, 1);
    fc(2'h2, 0, 0, 1, MCH, 5, 1, 1);
    fc(2'h3, 1, 1, 1, ID, 6, 1, 0);
    fc(2'h3, 1, 0, 1, OTH, 6, 1, 1);
    fc(2'h3, 0, 1, 1, OTH, 6, 1, 1);
  endtask

  // Disable the link again: even accept-all drops frames
  task automatic t_disable();
    logic [31:0] q;
    logic [1:0] ar;
    bus(1'b1, `OFS_TX_MODE, 32'h2, q);
    bus(1'b1, `OFS_CONFIG0, 32'hb0, q);
    u_net.send(OTH, 1'b0, 6'h0, 1'b1, ar);
    check("disabled frame", ar, 48'h1);
    check("link off", link_disable, 48'h1);
    bus(1'b0, `OFS_STATUS, 32'h0, q);
    check("status", q, 48'h0e0b02);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_setup();
    t_filter();
    t_disable();
    results();
  end
endmodule // rx_address_filter_config_bench

`default_nettype wire
